// >>> nfh_cycle.sv
/*
 One flash bus cycle (write or read) driven from flip-flops.
 Assumes the flash samples address on the later falling strobe and data on the first rising one.
*/
`timescale 1ns/1ps
`default_nettype none
module nfh_cycle #(
	parameter int AW = 23
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          ce,
	// Request
	input  wire logic          start,
	input  wire logic          is_read,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic               done,
	output logic [7:0]         rdata,
	// Flash pins
	input  wire logic [7:0]    dq_i,
	output logic [AW-1:0]      a_o,
	output logic [7:0]         dq_o,
	output logic               dq_oe,
	output logic               ce_n,
	output logic               we_n,
	output logic               oe_n
);
	typedef enum logic [3:0] {
		C_IDLE  = 4'b0001,
		C_SETUP = 4'b0010,
		C_PULSE = 4'b0100,
		C_HOLD  = 4'b1000
	} nfh_cst_t;
	typedef struct packed {
		nfh_cst_t      st;
		logic [3:0]    cnt;
		logic          rd;
		logic          done;
		logic [7:0]    rdata;
		logic [AW-1:0] a;
		logic [7:0]    dq;
		logic          oe;
		logic          ce_n;
		logic          we_n;
		logic          oe_n;
	} nfh_cyc_t;
	nfh_cyc_t s_q, s_d;

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			C_IDLE: begin
				if (start) begin
					// Address and data set up with strobes high; CE# and WE# (OE# on reads) fall together
					s_d.st  = C_SETUP;
					s_d.rd  = is_read;
					s_d.a   = addr;
					s_d.dq  = wdata;
					s_d.oe  = !is_read;
					s_d.cnt = nfh_pkg::CYC_SETUP;
				end
			end
			C_SETUP: begin
				if (s_q.cnt <= 4'h1) begin
					s_d.st   = C_PULSE;
					s_d.ce_n = 1'b0;
					// Both strobes fall at once so the later one is well defined
					s_d.we_n = s_q.rd;
					s_d.oe_n = !s_q.rd;
					s_d.cnt  = s_q.rd ? nfh_pkg::CYC_READ : nfh_pkg::CYC_PULSE;
				end else begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
			end
			C_PULSE: begin
				if (s_q.cnt <= 4'h1) begin
					// WE# rises before CE#, data still held so it latches cleanly
					s_d.st    = C_HOLD;
					s_d.we_n  = 1'b1;
					s_d.oe_n  = 1'b1;
					s_d.rdata = dq_i;
					s_d.cnt   = nfh_pkg::CYC_HOLD;
				end else begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
			end
			C_HOLD: begin
				s_d.ce_n = 1'b1;
				if (s_q.cnt <= 4'h1) begin
					s_d.st   = C_IDLE;
					s_d.oe   = 1'b0;
					s_d.done = 1'b1;
				end else begin
					s_d.cnt = s_q.cnt - 4'h1;
				end
			end
			default: s_d.st = C_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q      <= '0;
			s_q.st   <= C_IDLE;
			s_q.ce_n <= 1'b1;
			s_q.we_n <= 1'b1;
			s_q.oe_n <= 1'b1;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign done  = s_q.done;
	assign rdata = s_q.rdata;
	assign a_o   = s_q.a;
	assign dq_o  = s_q.dq;
	assign dq_oe = s_q.oe;
	assign ce_n  = s_q.ce_n;
	assign we_n  = s_q.we_n;
	assign oe_n  = s_q.oe_n;
endmodule : nfh_cycle
`default_nettype wire

// >>> nfh_flash_mdl.sv
/*
 Behavioural byte-wide NOR flash device for the nfh_host bench.
 Assumes strobes from the host; program is instant, erase ends after ERS_RD polls.
*/
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_mdl #(
	parameter int         AW     = 23,
	parameter logic [7:0] ID_B   = 8'h3C, // Arbitrary id byte
	parameter int         ERS_RD = 40
) (
	// Flash pins
	input  wire logic [AW-1:0] A,
	input  wire logic [7:0]    D_I,
	input  wire logic          CE_N,
	input  wire logic          WE_N,
	input  wire logic          OE_N,
	output logic [7:0]         D_O
);
	logic [7:0]    mem [256];
	logic [7:0]    wbv [256];
	logic          wbm [256];
	logic [AW-1:0] la, ws;
	int            md, sq, wst, wn, wcy, ebusy;
	logic          pg, e1, sus, cf, cont_ok, bad, tg;
	logic [7:0]    q = 8'h00;
	wire           strb = WE_N | CE_N;
	initial begin
		foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
		{pg, e1, sus, cf, cont_ok, bad, tg} = '0;
		md = 0; sq = 0; wst = 0; ebusy = 0;
	end
	task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
		logic [11:0] lo;
		lo = a[11:0];
		if (wst > 0) wcy++;
		if (d == 8'hF0 && !pg && wst < 2) begin
			md = 0; sq = 0; wst = 0; e1 = 0;
		end else if (pg) begin mem[a[7:0]] = d; pg = 0; end
		else if (wst == 1) begin wn = d; wst = 2; foreach (wbm[i]) wbm[i] = 0; end
		else if (wst == 2) begin
			if (wcy == 5) ws = a; else if (a[AW-1:6] != ws[AW-1:6]) bad = 1;
			wbv[a[7:0]] = d; wbm[a[7:0]] = 1; wn--;
			if (wn < 0) wst = 3;
		end else if (wst == 3) begin
			if (d == 8'h29 && a[AW-1:15] == ws[AW-1:15] && wcy <= 69) begin
				foreach (mem[i]) if (wbm[i]) mem[i] = wbv[i];
			end else bad = 1;
			wst = 0;
		end else if (d == 8'h98 && lo[7:0] == 8'hAA && md < 2) md = 2;
		else if (sq == 1) sq = (d == 8'h55 && lo == 12'h555) ? 2 : 0;
		else if (sq == 2) begin
			sq = 0;
			case (d)
				8'h90: md = 1;
				8'hA0: pg = 1;
				8'h25: begin wst = 1; wcy = 3; end
				8'h80: e1 = 1;
				8'h30, 8'h10: if (e1) begin ebusy = ERS_RD; e1 = 0; end
				default: ;
			endcase
		end else if (d == 8'hAA && lo == 12'hAAA) sq = 1;
		else if (d == 8'h70 && lo == 12'hAAA) md = 3;
		else if (d == 8'hB0 && ebusy > 0) sus = 1;
		else if (d == 8'h30 && sus) sus = 0;
		else if (d == 8'hFF && a[7:0] == 8'hAB) cf = 1;
		else if (d == 8'h00 && cf && a[7:0] == 8'h54) cont_ok = 1;
	endtask : wr
	function automatic logic [7:0] rd(input logic [AW-1:0] a);
		if (ebusy > 0 && !sus) begin ebusy--; tg = ~tg; return {1'b0, tg, 6'h00}; end
		case (md)
			1: case (a[7:0])
				8'h00: return 8'h1B;
				8'h04: return (a[AW-1:15] == 1) ? 8'h01 : 8'h00;
				default: return ID_B;
			endcase
			2: return 8'hC3;
			3: begin md = 0; return a[0] ? 8'h5A : 8'h80; end
			default: return mem[a[7:0]];
		endcase
	endfunction : rd
	always @(negedge strb) la = A;
	always @(posedge strb) if (!$isunknown({la, D_I})) wr(la, D_I);
	always @(negedge OE_N or negedge CE_N) if (!OE_N && !CE_N) q = rd(A);
	// Released bus shows the inverse, so a stale sample cannot pass
	always @(posedge OE_N or posedge CE_N) q = ~q;
	assign D_O = q;
endmodule : nfh_flash_mdl
`default_nettype wire

// >>> nfh_host.sv
/*
 Host-side command sequencer for a byte-wide NOR flash: turns one operation request into
 the flash's unlock, command, data and read cycles and returns read data.
 Assumes a single MCLK domain; the flash bus pins are driven through nfh_cycle.
*/
// Operation
// - Buffer slot addresses stay in one page (not enforced here: slots run on from the start address)
// - Load count written as locations minus one
// - Reset leaves autoselect or after fail bit
// - Buffered write at most 69 cycles
// - Full identification read in three cycles
// - Buffer programs on confirm 29 to sector
// - Continuity check writes FF then 00
// - Bad sequence needs reset to recover
`timescale 1ns/1ps
`default_nettype none
module nfh_host #(
	parameter int AW       = 23,
	parameter int BUF_MAX  = nfh_pkg::BUF_MAX_BYTES,
	parameter bit BOOT_SEC = 1'b0
) (
	// Clock, reset, enable
	input  wire logic          MCLK,
	input  wire logic          RST,
	input  wire logic          CLK_EN,
	// Operation request
	input  wire logic          REQ_VALID,
	input  wire logic [3:0]    REQ_OP,
	input  wire logic [AW-1:0] REQ_ADDR,
	input  wire logic [7:0]    REQ_DATA,
	input  wire logic [6:0]    REQ_COUNT,
	output logic               REQ_READY,
	// Buffered-write data stream
	input  wire logic [7:0]    WB_DATA,
	output logic               WB_TAKE,
	// Answer
	output logic               RSP_VALID,
	output logic [23:0]        RSP_DATA,
	output logic               RSP_REFUSED,
	output logic               SUSPENDED,
	output logic               ERASING,
	// Flash pins
	input  wire logic [7:0]    FL_DQ_I,
	output logic [AW-1:0]      FL_A,
	output logic [7:0]         FL_DQ_O,
	output logic               FL_DQ_OE,
	output logic               FL_CE_N,
	output logic               FL_WE_N,
	output logic               FL_OE_N
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b001,
		H_RUN  = 3'b010,
		H_RESP = 3'b100
	} nfh_hst_t;
	typedef enum logic [1:0] {
		M_READ = 2'h0,
		M_ID   = 2'h1,
		M_CFI  = 2'h2
	} nfh_mode_t;
	typedef struct packed {
		nfh_hst_t      st;
		nfh_pkg::nfh_op_t op;
		logic [6:0]    step;
		logic [6:0]    cnt;
		logic [AW-1:0] addr;
		logic [7:0]    data;
		logic          busy;
		logic [23:0]   acc;
		nfh_mode_t     mode;
		logic          erasing;
		logic          susp;
		logic          rsp_v;
		logic          refused;
		logic          rsp_ref;
		logic          take;
	} nfh_state_t;
	nfh_state_t s_q, s_d;

	logic          cyc_done;
	logic [7:0]    cyc_rdata;
	logic          cyc_start;
	logic          cyc_rd;
	logic [AW-1:0] cyc_addr;
	logic [7:0]    cyc_wdata;
	logic          seq_last;

	// Command cycle address: upper bits held zero since the flash ignores them
	function automatic logic [AW-1:0] cmd_addr(input logic [11:0] low);
		cmd_addr = {{(AW-12){1'b0}}, low};
	endfunction
	// Any address inside the target sector
	function automatic logic [AW-1:0] sect_addr(input logic [AW-1:0] a);
		int lsb;
		lsb = BOOT_SEC ? nfh_pkg::SECT_LSB_BOOT : nfh_pkg::SECT_LSB_UNI;
		sect_addr = (a >> lsb) << lsb;
	endfunction

	//////////////////////////////////////////////////////////////////////////////////////
	// Per-step bus cycle table
	always_comb begin
		cyc_rd    = 1'b0;
		cyc_addr  = cmd_addr(nfh_pkg::ADDR_AAA);
		cyc_wdata = nfh_pkg::D_UNL1;
		seq_last  = 1'b0;
		if (s_q.step == 7'd1) begin
			cyc_addr  = cmd_addr(nfh_pkg::ADDR_555);
			cyc_wdata = nfh_pkg::D_UNL2;
		end
		case (s_q.op)
			nfh_pkg::OP_READ: begin
				cyc_rd   = 1'b1;
				cyc_addr = s_q.addr;
				seq_last = 1'b1;
			end
			nfh_pkg::OP_RESET, nfh_pkg::OP_RESUME, nfh_pkg::OP_SUSPEND: begin
				cyc_addr  = '0;
				cyc_wdata = (s_q.op == nfh_pkg::OP_RESET) ? nfh_pkg::D_RESET :
					(s_q.op == nfh_pkg::OP_SUSPEND) ? nfh_pkg::D_SUSP : nfh_pkg::D_RESUME;
				seq_last  = 1'b1;
			end
			nfh_pkg::OP_CFI: begin
				cyc_addr  = cmd_addr(nfh_pkg::ADDR_CFI);
				cyc_wdata = nfh_pkg::D_CFI;
				seq_last  = 1'b1;
			end
			nfh_pkg::OP_SRCLEAR: begin
				cyc_wdata = nfh_pkg::D_SRCLR;
				seq_last  = 1'b1;
			end
			nfh_pkg::OP_SRREAD: begin
				if (s_q.step == 7'd0) begin
					cyc_wdata = nfh_pkg::D_SRRD;
				end else begin
					// Low address bit picks status bits 0-7 or 8-15
					cyc_rd   = 1'b1;
					cyc_addr = {{(AW-1){1'b0}}, s_q.addr[0]};
					seq_last = 1'b1;
				end
			end
			nfh_pkg::OP_PROGRAM, nfh_pkg::OP_ABORT: begin
				if (s_q.step == 7'd2) begin
					cyc_wdata = (s_q.op == nfh_pkg::OP_ABORT) ? nfh_pkg::D_RESET : nfh_pkg::D_PROG;
					seq_last  = (s_q.op == nfh_pkg::OP_ABORT);
				end else if (s_q.step == 7'd3) begin
					cyc_addr  = s_q.addr;
					cyc_wdata = s_q.data;
					seq_last  = 1'b1;
				end
			end
			nfh_pkg::OP_SERASE, nfh_pkg::OP_CERASE: begin
				if (s_q.step == 7'd2) begin
					cyc_wdata = nfh_pkg::D_ERS1;
				end else if (s_q.step == 7'd4) begin
					cyc_addr  = cmd_addr(nfh_pkg::ADDR_555);
					cyc_wdata = nfh_pkg::D_UNL2;
				end else if (s_q.step == 7'd5) begin
					cyc_addr  = (s_q.op == nfh_pkg::OP_SERASE) ? sect_addr(s_q.addr) : cyc_addr;
					cyc_wdata = (s_q.op == nfh_pkg::OP_SERASE) ? nfh_pkg::D_SERS : nfh_pkg::D_CERS;
					seq_last  = 1'b1;
				end
			end
			nfh_pkg::OP_ID, nfh_pkg::OP_PROTVFY: begin
				if (s_q.step == 7'd2) begin
					cyc_wdata = nfh_pkg::D_ID;
				end else if (s_q.step >= 7'd3) begin
					// Identification continues with reads, three of them for the full code
					cyc_rd   = 1'b1;
					cyc_addr = (s_q.op == nfh_pkg::OP_PROTVFY) ?
						(sect_addr(s_q.addr) | cmd_addr(nfh_pkg::ADDR_PROT)) :
						(s_q.step == 7'd3) ? cmd_addr(nfh_pkg::ADDR_DEV) :
						(s_q.step == 7'd4) ? cmd_addr(nfh_pkg::ADDR_DEV2) :
						cmd_addr(nfh_pkg::ADDR_DEV3);
					seq_last = (s_q.op == nfh_pkg::OP_PROTVFY) || (s_q.step == 7'd5);
				end
			end
			nfh_pkg::OP_WBUF: begin
				if (s_q.step == 7'd2) begin
					cyc_addr  = sect_addr(s_q.addr);
					cyc_wdata = nfh_pkg::D_WBUF;
				end else if (s_q.step == 7'd3) begin
					cyc_addr  = sect_addr(s_q.addr);
					cyc_wdata = {1'b0, s_q.cnt};
				end else if (s_q.step == s_q.cnt + 7'd5) begin
					cyc_addr  = sect_addr(s_q.addr);
					cyc_wdata = nfh_pkg::D_CONF;
					seq_last  = 1'b1;
				end else if (s_q.step >= 7'd4) begin
					// Slots advance from the start address; they stay inside one page only when start offset plus load count fits in the 64-byte page
					cyc_addr  = s_q.addr + AW'(s_q.step - 7'd4);
					cyc_wdata = WB_DATA;
				end
			end
			nfh_pkg::OP_CONTCHK: begin
				cyc_rd    = (s_q.step == 7'd2) || (s_q.step == 7'd6);
				cyc_wdata = (s_q.step == 7'd0) ? nfh_pkg::D_SRCLR :
					(s_q.step == 7'd3) ? nfh_pkg::D_FF :
					(s_q.step == 7'd4) ? nfh_pkg::D_00 : nfh_pkg::D_SRRD;
				// Pattern addresses come from the request, sized to the part
				cyc_addr  = (s_q.step == 7'd3) ? s_q.addr :
					(s_q.step == 7'd4) ? ~s_q.addr : cmd_addr(nfh_pkg::ADDR_AAA);
				seq_last  = (s_q.step == 7'd6);
			end
			default: seq_last = 1'b1;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////////////
	// Request sequencing
	assign cyc_start = (s_q.st == H_RUN) && !s_q.busy;

	always_comb begin
		logic ok;
		ok        = 1'b1;
		s_d       = s_q;
		s_d.rsp_v = 1'b0;
		s_d.take  = 1'b0;
		// Refusal is shown only alongside its answer
		s_d.rsp_ref = 1'b0;
		case (s_q.st)
			H_IDLE: begin
				if (REQ_VALID) begin
					s_d.op   = nfh_pkg::nfh_op_t'(REQ_OP);
					s_d.addr = REQ_ADDR;
					s_d.data = REQ_DATA;
					// Buffered writes longer than the 69-cycle limit are clipped
					s_d.cnt  = (REQ_COUNT > 7'(BUF_MAX - 1)) ? 7'(BUF_MAX - 1) : REQ_COUNT;
					s_d.step = '0;
					s_d.acc  = '0;
					case (nfh_pkg::nfh_op_t'(REQ_OP))
						nfh_pkg::OP_SUSPEND: ok = s_q.erasing && !s_q.susp;
						nfh_pkg::OP_RESUME:  ok = s_q.susp;
						nfh_pkg::OP_CFI:     ok = (s_q.mode != M_CFI) && !s_q.erasing;
						nfh_pkg::OP_SERASE, nfh_pkg::OP_CERASE: ok = !s_q.erasing;
						default:             ok = 1'b1;
					endcase
					if (ok) begin
						s_d.st = H_RUN;
					end else begin
						s_d.st      = H_RESP;
						s_d.refused = 1'b1;
					end
				end
			end
			H_RUN: begin
				if (cyc_start) begin
					s_d.busy = 1'b1;
					s_d.take = (s_q.op == nfh_pkg::OP_WBUF) && (s_q.step >= 7'd4) && !seq_last;
				end else if (cyc_done) begin
					s_d.busy = 1'b0;
					if (cyc_rd) begin
						s_d.acc = {s_q.acc[15:0], cyc_rdata};
					end
					if (seq_last) begin
						s_d.st      = H_RESP;
						s_d.refused = 1'b0;
					end else begin
						s_d.step = s_q.step + 7'd1;
					end
				end
			end
			H_RESP: begin
				s_d.rsp_v   = 1'b1;
				s_d.rsp_ref = s_q.refused;
				s_d.st      = H_IDLE;
				if (!s_q.refused) begin
					case (s_q.op)
						nfh_pkg::OP_RESET: begin
							// Back to read, or erase-suspend-read when suspended
							s_d.mode = M_READ;
						end
						nfh_pkg::OP_ID, nfh_pkg::OP_PROTVFY: s_d.mode = M_ID;
						nfh_pkg::OP_CFI:    s_d.mode = M_CFI;
						nfh_pkg::OP_SERASE: s_d.erasing = 1'b1;
						nfh_pkg::OP_SUSPEND: s_d.susp = 1'b1;
						nfh_pkg::OP_RESUME:  s_d.susp = 1'b0;
						default: s_d.mode = s_q.mode;
					endcase
				end
			end
			default: s_d.st = H_IDLE;
		endcase
		// Erase completion is not observed here; a reset command clears the tracking unless suspended
		if (s_q.st == H_RESP && !s_q.refused && s_q.op == nfh_pkg::OP_RESET && !s_q.susp) begin
			s_d.erasing = 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			s_q      <= '0;
			s_q.st   <= H_IDLE;
			s_q.mode <= M_READ;
		end else if (CLK_EN) begin
			s_q <= s_d;
		end
	end

	nfh_cycle #(
		.AW (AW)
	) u_cycle (
		.clk     (MCLK),
		.rst     (RST),
		.ce      (CLK_EN),
		.start   (cyc_start),
		.is_read (cyc_rd),
		.addr    (cyc_addr),
		.wdata   (cyc_wdata),
		.done    (cyc_done),
		.rdata   (cyc_rdata),
		.dq_i    (FL_DQ_I),
		.a_o     (FL_A),
		.dq_o    (FL_DQ_O),
		.dq_oe   (FL_DQ_OE),
		.ce_n    (FL_CE_N),
		.we_n    (FL_WE_N),
		.oe_n    (FL_OE_N)
	);

	assign REQ_READY   = (s_q.st == H_IDLE);
	assign WB_TAKE     = s_q.take;
	assign RSP_VALID   = s_q.rsp_v;
	assign RSP_DATA    = s_q.acc;
	assign RSP_REFUSED = s_q.rsp_ref;
	assign SUSPENDED   = s_q.susp;
	assign ERASING     = s_q.erasing;
endmodule : nfh_host
`default_nettype wire

// >>> nfh_host_sva.sv
/*
 Pin-level checker for nfh_host.
 Assumes it is bound from the bench top and sees only the top module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module nfh_host_sva #(
	parameter int AW = 23
) (
	// Clock and reset
	input wire logic          MCLK,
	input wire logic          RST,
	// Status
	input wire logic          RSP_VALID,
	input wire logic          RSP_REFUSED,
	input wire logic          SUSPENDED,
	input wire logic          ERASING,
	// Flash pins
	input wire logic [AW-1:0] FL_A,
	input wire logic [7:0]    FL_DQ_O,
	input wire logic          FL_DQ_OE,
	input wire logic          FL_CE_N,
	input wire logic          FL_WE_N,
	input wire logic          FL_OE_N
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	// End of a write pulse: data is latched here, so it must not move yet
	sequence s_wend;
		!FL_WE_N ##1 FL_WE_N;
	endsequence
	sequence s_susp_start;
		$rose(SUSPENDED);
	endsequence
	chk_we_with_ce: assert property (!FL_WE_N |-> !FL_CE_N)
		else $error("write strobe without chip select");
	chk_oe_with_ce: assert property (!FL_OE_N |-> !FL_CE_N)
		else $error("read strobe without chip select");
	chk_rw_apart: assert property (!(!FL_WE_N && !FL_OE_N))
		else $error("read and write strobes low together");
	chk_wr_drives: assert property (!FL_WE_N |-> FL_DQ_OE)
		else $error("data not driven during write pulse");
	chk_rd_release: assert property (!FL_OE_N |-> !FL_DQ_OE)
		else $error("data driven during read");
	chk_wdata_hold: assert property (s_wend |-> $stable(FL_A) && $stable(FL_DQ_O) && FL_DQ_OE)
		else $error("address or data moved at write strobe rise");
	chk_susp_cause: assert property (s_susp_start |-> $past(ERASING))
		else $error("suspend entered without running erase");
	chk_refuse_rsp: assert property (RSP_REFUSED |-> RSP_VALID)
		else $error("refusal flag outside an answer");
	chk_reset_idle: assert property (disable iff (1'b0) RST |=> FL_CE_N && FL_WE_N && FL_OE_N)
		else $error("bus not idle after reset");
endmodule : nfh_host_sva
`default_nettype wire

// >>> nfh_host_tb_top.sv
/*
 Self-checking bench for nfh_host with the flash model on its pins.
 Assumes one MCLK domain; every operation returns one answer.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin miscompares++; \
	$display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp); end end
module nfh_host_tb_top;
	localparam int         AW   = 23;
	localparam logic [7:0] ID_B = 8'h3C;
	localparam logic [24:0] WOK = 25'h1000000;
	localparam logic [24:0] BM  = 25'h10000FF;
	logic          MCLK = 0, RST = 1, REQ_VALID = 0;
	logic [3:0]    REQ_OP = '0;
	logic [AW-1:0] REQ_ADDR = '0, FL_A;
	logic [7:0]    REQ_DATA = '0, WB_DATA = '0, FL_DQ_I, FL_DQ_O, mdl_q;
	logic [6:0]    REQ_COUNT = '0;
	logic [23:0]   RSP_DATA;
	logic          REQ_READY, WB_TAKE, RSP_VALID, RSP_REFUSED, SUSPENDED, ERASING;
	logic          FL_DQ_OE, FL_CE_N, FL_WE_N, FL_OE_N;
	logic [24:0]   expv [$], expm [$];
	logic [7:0]    shd [256], wbb [64];
	logic [31:0]   seed = 32'd83967;
	int            miscompares = 0, samples_checked = 0, wbi = 0;
	always #25 MCLK = ~MCLK;
	assign FL_DQ_I = FL_DQ_OE ? FL_DQ_O : mdl_q;
	nfh_host #(.AW(AW)) uut (.MCLK, .RST, .CLK_EN(1'b1), .REQ_VALID, .REQ_OP, .REQ_ADDR,
		.REQ_DATA, .REQ_COUNT, .REQ_READY, .WB_DATA, .WB_TAKE, .RSP_VALID, .RSP_DATA,
		.RSP_REFUSED, .SUSPENDED, .ERASING, .FL_DQ_I, .FL_A, .FL_DQ_O, .FL_DQ_OE,
		.FL_CE_N, .FL_WE_N, .FL_OE_N);
	nfh_flash_mdl #(.AW(AW), .ID_B(ID_B)) fl (.A(FL_A), .D_I(FL_DQ_I), .CE_N(FL_CE_N),
		.WE_N(FL_WE_N), .OE_N(FL_OE_N), .D_O(mdl_q));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////////////
	// Outputs are sampled mid-cycle, away from the edge that launches them
	always @(negedge MCLK) if (RSP_VALID === 1'b1) begin
		logic [24:0] e, m;
		e = 25'h0;
		m = 25'h1FFFFFF;
		if (expv.size() > 0) begin e = expv.pop_front(); m = expm.pop_front(); end
		`CHK({RSP_REFUSED, RSP_DATA} & m, e)
	end
	always @(negedge MCLK) if (WB_TAKE === 1'b1) begin wbi++; WB_DATA = wbb[wbi[5:0]]; end
	task automatic op(input logic [3:0] o, input logic [AW-1:0] a, input logic [7:0] d,
		input logic [24:0] e, input logic [24:0] m);
		int n;
		expv.push_back(e & m);
		expm.push_back(m);
		REQ_OP = o; REQ_ADDR = a; REQ_DATA = d; REQ_VALID = 1;
		n = 0;
		// Ready is checked off the edge; the next edge then takes the request
		while (REQ_READY !== 1'b1 && n < 500) begin @(posedge MCLK); #1; n++; end
		@(posedge MCLK);
		#1 REQ_VALID = 0;
		while (expv.size() > 0 && n < 5000) begin @(posedge MCLK); n++; end
		#1;
		if (n >= 5000) `CHK(n, 0)
	endtask : op
	task automatic rd(input logic [AW-1:0] a);
		op(nfh_pkg::OP_READ, a, 8'h00, {17'h0, shd[a[7:0]]}, BM);
	endtask : rd
	////////////////////////////////////////////////////////////////////////////////
	initial begin : main
		logic [AW-1:0] a;
		logic [7:0]    d;
		foreach (shd[i]) shd[i] = 8'(i) ^ 8'hA5;
		foreach (wbb[i]) wbb[i] = 8'(rnd());
		repeat (5) @(posedge MCLK);
		#1 RST = 0;
		repeat (2) @(posedge MCLK);
		#1 a = AW'(rnd());
		rd(a);
		a = AW'(rnd());
		d = 8'(rnd());
		op(nfh_pkg::OP_PROGRAM, a, d, 25'h0, WOK);
		shd[a[7:0]] = d;
		rd(a);
		a = AW'(rnd());
		a[5:0] = '0;
		REQ_COUNT = 7'd64;
		wbi = 0;
		WB_DATA = wbb[0];
		op(nfh_pkg::OP_WBUF, a, 8'h00, 25'h0, WOK);
		for (int i = 0; i < 64; i++) shd[{a[7:6], 6'(i)}] = wbb[i];
		for (int i = 0; i < 64; i += 21) rd({a[AW-1:6], 6'(i)});
		op(nfh_pkg::OP_ABORT, a, 8'h00, 25'h0, WOK);
		rd(a);
		op(nfh_pkg::OP_ID, '0, 8'h00, {1'b0, {3{ID_B}}}, 25'h1FFFFFF);
		op(nfh_pkg::OP_RESET, '0, 8'h00, 25'h0, WOK);
		op(nfh_pkg::OP_PROTVFY, AW'(23'h008000), 8'h00, 25'h01, BM);
		op(nfh_pkg::OP_PROTVFY, AW'(23'h010000), 8'h00, 25'h00, BM);
		op(nfh_pkg::OP_RESET, '0, 8'h00, 25'h0, WOK);
		op(nfh_pkg::OP_SRREAD, AW'(0), 8'h00, 25'h80, BM);
		op(nfh_pkg::OP_SRREAD, AW'(1), 8'h00, 25'h5A, BM);
		op(nfh_pkg::OP_SRCLEAR, '0, 8'h00, 25'h0, WOK);
		op(nfh_pkg::OP_CFI, '0, 8'h00, 25'h0, WOK);
		op(nfh_pkg::OP_READ, a, 8'h00, 25'hC3, BM);
		op(nfh_pkg::OP_CFI, '0, 8'h00, WOK, WOK);
		op(nfh_pkg::OP_RESET, '0, 8'h00, 25'h0, WOK);
		rd(a);
		op(nfh_pkg::OP_CONTCHK, AW'(23'h5554AB), 8'h00, 25'h0, WOK);
		`CHK(fl.cont_ok, 1'b1)
		op(nfh_pkg::OP_SUSPEND, '0, 8'h00, WOK, WOK);
		`CHK(SUSPENDED, 1'b0)
		op(nfh_pkg::OP_RESUME, '0, 8'h00, WOK, WOK);
		`CHK(SUSPENDED, 1'b0)
		op(nfh_pkg::OP_SERASE, AW'(23'h018000), 8'h00, 25'h0, WOK);
		`CHK(ERASING, 1'b1)
		op(nfh_pkg::OP_SUSPEND, '0, 8'h00, 25'h0, WOK);
		`CHK(SUSPENDED, 1'b1)
		rd(a);
		op(nfh_pkg::OP_RESUME, '0, 8'h00, 25'h0, WOK);
		`CHK(SUSPENDED, 1'b0)
		op(nfh_pkg::OP_CERASE, '0, 8'h00, WOK, WOK);
		op(nfh_pkg::OP_RESET, '0, 8'h00, 25'h0, WOK);
		op(nfh_pkg::OP_CERASE, '0, 8'h00, 25'h0, WOK);
		`CHK(fl.bad, 1'b0)
		end_of_test();
	end
	initial begin : watchdog
		#2000000;
		miscompares++;
		end_of_test();
	end
endmodule : nfh_host_tb_top
bind nfh_host nfh_host_sva #(.AW(AW)) u_sva (.MCLK, .RST, .RSP_VALID, .RSP_REFUSED,
	.SUSPENDED, .ERASING, .FL_A, .FL_DQ_O, .FL_DQ_OE, .FL_CE_N, .FL_WE_N, .FL_OE_N);
`default_nettype wire

// >>> nfh_pkg.sv
/*
 Constants for the host-side command sequencer of a byte-wide parallel NOR flash.
 Assumes a 20 MHz system clock and an asynchronous flash bus driven from flip-flops.
*/
`default_nettype none
package nfh_pkg;
	// Command addresses, byte mode
	localparam logic [11:0] ADDR_AAA   = 12'hAAA;
	localparam logic [11:0] ADDR_555   = 12'h555;
	localparam logic [11:0] ADDR_CFI   = 12'h0AA;
	localparam logic [11:0] ADDR_MFR   = 12'h000;
	localparam logic [11:0] ADDR_DEV   = 12'h002;
	localparam logic [11:0] ADDR_PROT  = 12'h004;
	localparam logic [11:0] ADDR_DEV2  = 12'h01C;
	localparam logic [11:0] ADDR_DEV3  = 12'h01E;
	// Command data
	localparam logic [7:0] D_UNL1   = 8'hAA;
	localparam logic [7:0] D_UNL2   = 8'h55;
	localparam logic [7:0] D_RESET  = 8'hF0;
	localparam logic [7:0] D_ID     = 8'h90;
	localparam logic [7:0] D_PROG   = 8'hA0;
	localparam logic [7:0] D_WBUF   = 8'h25;
	localparam logic [7:0] D_CONF   = 8'h29;
	localparam logic [7:0] D_ERS1   = 8'h80;
	localparam logic [7:0] D_SERS   = 8'h30;
	localparam logic [7:0] D_CERS   = 8'h10;
	localparam logic [7:0] D_SUSP   = 8'hB0;
	localparam logic [7:0] D_RESUME = 8'h30;
	localparam logic [7:0] D_CFI    = 8'h98;
	localparam logic [7:0] D_SRRD   = 8'h70;
	localparam logic [7:0] D_SRCLR  = 8'h71;
	localparam logic [7:0] D_FF     = 8'hFF;
	localparam logic [7:0] D_00     = 8'h00;
	// Protection verify answers
	localparam logic [7:0] PROT_NO  = 8'h00;
	localparam logic [7:0] PROT_YES = 8'h01;
	// Buffer and sequence limits
	localparam int BUF_MAX_BYTES = 64;
	localparam int SEQ_MAX_CYC   = 69;
	// Sector boundary bits
	localparam int SECT_LSB_UNI  = 15;
	localparam int SECT_LSB_BOOT = 12;
	// Bus cycle phases in MCLK cycles (50 ns each)
	localparam int T_CLK_NS   = 50;
	localparam int T_SETUP_NS = 50;
	localparam int T_PULSE_NS = 50;
	localparam int T_READ_NS  = 100;
	localparam int T_HOLD_NS  = 50;
	localparam logic [3:0] CYC_SETUP = 4'((T_SETUP_NS + T_CLK_NS - 1) / T_CLK_NS);
	localparam logic [3:0] CYC_PULSE = 4'((T_PULSE_NS + T_CLK_NS - 1) / T_CLK_NS);
	localparam logic [3:0] CYC_READ  = 4'((T_READ_NS + T_CLK_NS - 1) / T_CLK_NS);
	localparam logic [3:0] CYC_HOLD  = 4'((T_HOLD_NS + T_CLK_NS - 1) / T_CLK_NS);
	// Host operation codes
	typedef enum logic [3:0] {
		OP_READ     = 4'h0,
		OP_RESET    = 4'h1,
		OP_PROGRAM  = 4'h2,
		OP_WBUF     = 4'h3,
		OP_ABORT    = 4'h4,
		OP_SERASE   = 4'h5,
		OP_CERASE   = 4'h6,
		OP_SUSPEND  = 4'h7,
		OP_RESUME   = 4'h8,
		OP_CFI      = 4'h9,
		OP_ID       = 4'hA,
		OP_PROTVFY  = 4'hB,
		OP_SRREAD   = 4'hC,
		OP_SRCLEAR  = 4'hD,
		OP_CONTCHK  = 4'hE
	} nfh_op_t;
endpackage : nfh_pkg
`default_nettype wire
